// ===== cioimg_consts.vh
// Constants for the configurable I/O process image block
`ifndef CIOIMG_CONSTS_VH
`define CIOIMG_CONSTS_VH

`define CIO_A_CTRL        12'h000
`define CIO_A_OUTIMG      12'h004
`define CIO_A_CFG         12'h008
`define CIO_A_INIMG0      12'h00C
`define CIO_A_INIMG1      12'h010
`define CIO_A_STATUS      12'h014
`define CIO_A_ROTARY      12'h018

`define CIO_CTRL_CONN     0
`define CIO_CTRL_OWNER    1
`define CIO_CTRL_VALID    2
`define CIO_CTRL_BOOTED   3
`define CIO_CTRL_FWUPD    4
`define CIO_CTRL_RING     5

`define CIO_ST_SHORT      0
`define CIO_ST_OVL        1
`define CIO_ST_SUPOVL     4
`define CIO_ST_UNDERV     5
`define CIO_ST_READYCON   8
`define CIO_ST_READYCYC   9
`define CIO_ST_RESTORE    10
`define CIO_ST_RINGFLT    11

`define CIO_SUB_LOW       8'h00
`define CIO_SUB_HIGH      8'h01
`define CIO_SUB_HOLD      8'h02
`define CIO_SUB_PATTERN   8'h03
`define CIO_SUB_RESET     8'h00
`define CIO_CTRL_RESET    6'h00
`define CIO_OUT_RESET     16'h0000
`define CIO_ROT_RESET     8'h00
`define CIO_PAT_RESET     16'h0000
`define CIO_ROTARY_RESTORE 8'h0F

`define CIO_CLK_HZ        25000000
`define CIO_CONN_MS       350
`define CIO_CYC_MS        500
`define CIO_RING_US       3000
`define CIO_BLINK_HZ      2
`define CIO_IN_BYTES      6
`define CIO_OUT_BYTES     2
`define CIO_CFG_BYTES     3

`endif

// ===== cioimg_top.v
// Process image, substitute outputs and indicators of the 16-channel I/O
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cioimg_consts.vh"

module cioimg_top #(
  parameter integer CONN_CYC = `CIO_CONN_MS * (`CIO_CLK_HZ / 1000) - 1,
  parameter integer CYC_CYC  = `CIO_CYC_MS * (`CIO_CLK_HZ / 1000) - 1,
  parameter integer RING_CYC = `CIO_RING_US * (`CIO_CLK_HZ / 1000000) - 1,
  parameter integer BLINK_CYC = `CIO_CLK_HZ / (2 * `CIO_BLINK_HZ)
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Channel pins, output enable low while driven
  input  wire [15:0] chanIn,
  output reg  [15:0] chanOut,
  output reg  [15:0] chanOutEn,
  // Fault sensing
  input  wire        faultShort,
  input  wire        faultOverload,
  input  wire        faultSupplyOvl,
  input  wire        faultUnderVolt,
  input  wire        ringFault,
  // Indicators
  output reg         netLedGreen,
  output reg         rdyLedYellow,
  output reg         restoreDefaults
);

  reg  [15:0] outImg_r;
  reg  [7:0]  subCode_r;
  reg  [15:0] subPat_r;
  reg  [5:0]  ctrl_r;
  reg  [7:0]  rotary_r;
  reg  [15:0] usedOut_r;
  reg  [15:0] lastOut_r;
  reg  [15:0] inImg_r;
  reg  [31:0] status_r;
  reg  [31:0] upCnt_r;
  reg  [31:0] ringCnt_r;
  reg  [31:0] blinkCnt_r;
  reg         blink_r;
  reg         readyCon_r;
  reg         readyCyc_r;
  reg         ringFlt_r;
  reg  [15:0] drive;
  reg         mapped;

  wire        wrEn;
  wire        validImg;
  wire        restoring;
  wire [15:0] usedIn;

  // Channel count is fixed by the two-byte image layout
  localparam CHANNELS = 16;
  genvar     ch;

  // Zero wait states: every register answers from a flop
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;

  // Unmapped offsets raise an error; writes there are dropped
  always @* begin
    case (paddr)
      `CIO_A_CTRL,
      `CIO_A_OUTIMG,
      `CIO_A_CFG,
      `CIO_A_INIMG0,
      `CIO_A_INIMG1,
      `CIO_A_STATUS,
      `CIO_A_ROTARY: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~mapped;
  // Restore position: configuration and usage return to defaults
  assign restoring = (rotary_r == `CIO_ROTARY_RESTORE);
  // Output data only counts for an exclusive-owner connection
  assign validImg = ctrl_r[`CIO_CTRL_CONN] & ctrl_r[`CIO_CTRL_OWNER] &
                    ctrl_r[`CIO_CTRL_VALID] & readyCyc_r;
  // A channel the controller never wrote as output is an input
  assign usedIn = ~usedOut_r;

  // Connection control and output image; frozen while restoring
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= `CIO_CTRL_RESET;
      outImg_r <= `CIO_OUT_RESET;
    end else if (wrEn && !restoring) begin
      if (paddr == `CIO_A_CTRL)
        ctrl_r <= pwdata[5:0];
      if (paddr == `CIO_A_OUTIMG)
        outImg_r <= pwdata[15:0];
    end
  end

  // Configuration record
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      subCode_r <= `CIO_SUB_RESET;
      subPat_r  <= `CIO_PAT_RESET;
    end else if (restoring) begin
      subCode_r <= `CIO_SUB_RESET;
      subPat_r  <= `CIO_PAT_RESET;
    end else if (wrEn && paddr == `CIO_A_CFG) begin
      // Codes above 3 are out of range and ignored
      if (pwdata[7:0] <= `CIO_SUB_PATTERN)
        subCode_r <= pwdata[7:0];
      // The pattern is stored even when the code is refused
      subPat_r <= pwdata[23:8];
    end
  end

  // Channel usage: a bit written high claims output direction
  always @(posedge clk or posedge rst) begin
    if (rst)
      usedOut_r <= `CIO_OUT_RESET;
    else if (restoring)
      usedOut_r <= `CIO_OUT_RESET;
    else if (wrEn && paddr == `CIO_A_OUTIMG)
      usedOut_r <= usedOut_r | pwdata[15:0];
  end

  // Selector stays writable so the restore position can be left
  always @(posedge clk or posedge rst) begin
    if (rst)
      rotary_r <= `CIO_ROT_RESET;
    else if (wrEn && paddr == `CIO_A_ROTARY)
      rotary_r <= pwdata[7:0];
  end

  // Substitute selection
  always @* begin
    if (validImg)
      drive = outImg_r;
    else begin
      case (subCode_r)
        `CIO_SUB_LOW:     drive = 16'h0000;
        `CIO_SUB_HIGH:    drive = 16'hFFFF;
        // Hold replays the last image taken while valid
        `CIO_SUB_HOLD:    drive = lastOut_r;
        `CIO_SUB_PATTERN: drive = subPat_r;
        default:          drive = 16'h0000;
      endcase
    end
  end

  // Bit n drives channel n+1; odd channels on contact 4, even on 2
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          chanOut[ch]   <= 1'b0;
          chanOutEn[ch] <= 1'b1;
          lastOut_r[ch] <= 1'b0;
          inImg_r[ch]   <= 1'b0;
        end else begin
          // A claimed channel is never sampled as an input
          chanOut[ch]   <= drive[ch] & usedOut_r[ch];
          chanOutEn[ch] <= ~usedOut_r[ch];
          if (validImg)
            lastOut_r[ch] <= outImg_r[ch];
          // Input image lags the pins by one clock
          // Outputs mirror their state, inputs show the pin
          if (usedOut_r[ch])
            inImg_r[ch] <= chanOut[ch];
          else
            inImg_r[ch] <= chanIn[ch] & usedIn[ch];
        end
      end
    end
  endgenerate

  // Start-up readiness; the counter stops once ready so it cannot wrap
  // Connection requests are served before cyclic exchange starts
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upCnt_r    <= 32'h0000_0000;
      readyCon_r <= 1'b0;
      readyCyc_r <= 1'b0;
    end else begin
      if (!readyCyc_r)
        upCnt_r <= upCnt_r + 32'h0000_0001;
      if (upCnt_r == CONN_CYC[31:0])
        readyCon_r <= 1'b1;
      if (upCnt_r == CYC_CYC[31:0])
        readyCyc_r <= 1'b1;
    end
  end

  // Single ring only; a fault on the closing edge opens a new window
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ringCnt_r <= 32'h0000_0000;
      ringFlt_r <= 1'b0;
    end else if (ringFault &&
                 (!ringFlt_r || ringCnt_r == RING_CYC[31:0])) begin
      ringFlt_r <= 1'b1;
      ringCnt_r <= 32'h0000_0000;
    end else if (ringFlt_r) begin
      ringCnt_r <= ringCnt_r + 32'h0000_0001;
      if (ringCnt_r == RING_CYC[31:0])
        ringFlt_r <= 1'b0;
    end
  end

  // Status word, same layout for every family member
  // Reserved bits 2, 3 and 6 to 31 stay zero; the status offset read fills bits 8 to 11
  always @(posedge clk or posedge rst) begin
    if (rst)
      status_r <= 32'h0000_0000;
    else begin
      status_r <= 32'h0000_0000;
      status_r[`CIO_ST_SHORT]  <= faultShort;
      status_r[`CIO_ST_OVL]    <= faultOverload;
      status_r[`CIO_ST_SUPOVL] <= faultSupplyOvl;
      status_r[`CIO_ST_UNDERV] <= faultUnderVolt;
    end
  end

  // One flash clock keeps both indicators in step
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      blinkCnt_r <= 32'h0000_0000;
      blink_r    <= 1'b0;
    end else if (blinkCnt_r == BLINK_CYC[31:0] - 32'h0000_0001) begin
      blinkCnt_r <= 32'h0000_0000;
      blink_r    <= ~blink_r;
    end else
      blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
  end

  // Indicators
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      netLedGreen     <= 1'b0;
      rdyLedYellow    <= 1'b0;
      restoreDefaults <= 1'b0;
    end else begin
      // Steady with a connection, flashing while waiting for one
      netLedGreen <= ctrl_r[`CIO_CTRL_BOOTED] &
                     (ctrl_r[`CIO_CTRL_CONN] | blink_r);
      rdyLedYellow <= ctrl_r[`CIO_CTRL_FWUPD] & blink_r;
      restoreDefaults <= restoring;
    end
  end

  // Read data loads in the setup cycle and stands through access
  // Status word only in the low image carries reserved zeros
  always @(posedge clk or posedge rst) begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CIO_A_CTRL:   prdata <= {26'h000_0000, ctrl_r};
        `CIO_A_OUTIMG: prdata <= {16'h0000, outImg_r};
        `CIO_A_CFG:    prdata <= {8'h00, subPat_r, subCode_r};
        `CIO_A_INIMG0: prdata <= status_r;
        `CIO_A_INIMG1: prdata <= {16'h0000, inImg_r};
        `CIO_A_STATUS: prdata <= {20'h0_0000, ringFlt_r, restoreDefaults,
                                  readyCyc_r, readyCon_r, status_r[7:0]};
        `CIO_A_ROTARY: prdata <= {24'h00_0000, rotary_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // cioimg_top
`default_nettype wire

// ===== cioimg_field.sv
// Field wiring model for the sixteen channel pins
`timescale 1ns/1ns
`default_nettype none
module cioimg_field (
  // Pins and sensor levels
  input  wire logic [15:0] chanOut,
  input  wire logic [15:0] chanOutEn,
  input  wire logic [15:0] fieldLvl,
  output wire logic [15:0] chanIn
);
  // Sensors only reach channels the device does not drive
  assign chanIn = (chanOutEn & fieldLvl) | (~chanOutEn & chanOut);
endmodule // cioimg_field
`default_nettype wire

// ===== cioimg_chk.sv
// Port assertions for the process image block
`timescale 1ns/1ns
`default_nettype none
module cioimg_chk (
  // Clock, reset and bus
  input wire logic        clk, rst, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins and indicators
  input wire logic [15:0] chanIn, chanOut, chanOutEn,
  input wire logic        faultShort, faultOverload, faultSupplyOvl,
  input wire logic        faultUnderVolt, netLedGreen, rdyLedYellow,
  input wire logic        restoreDefaults, pslverr
);
  logic       wrO, wrC, rdS;
  logic [5:0] flt;
  logic [2:0] ctl_r;
  logic [7:0] up_r;
  assign wrO = psel & penable & pwrite & (paddr == 12'h004);
  assign wrC = psel & penable & pwrite & (paddr == 12'h000);
  assign rdS = psel & ~penable & ~pwrite;
  assign flt = {faultUnderVolt, faultSupplyOvl, 2'h0, faultOverload,
                faultShort};
  // Uptime saturates so the late checks stay armed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= 3'h0;
      up_r  <= 8'h00;
    end else begin
      if (up_r != 8'hff) up_r <= up_r + 8'h01;
      if (wrC) ctl_r <= pwdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_out;
    wrO && &ctl_r && up_r > 8'h2d |-> ##2
      (chanOut & ~chanOutEn) == ($past(pwdata[15:0], 2) & ~chanOutEn);
  endproperty
  a_out: assert property (p_out) else $error("outputs wrong");
  property p_en;
    |($past(chanOutEn) & ~chanOutEn) |-> $past(wrO) || $past(wrO, 2);
  endproperty
  a_en: assert property (p_en) else $error("direction wrong");
  property p_st;
    rdS && paddr == 12'h00c |=> prdata == {26'h0, $past(flt, 2)};
  endproperty
  a_st: assert property (p_st) else $error("status wrong");
  property p_in;
    rdS && paddr == 12'h010 |=> prdata[15:0] == $past(chanIn, 2);
  endproperty
  a_in: assert property (p_in) else $error("inputs wrong");
  property p_rot;
    psel && penable && pwrite && paddr == 12'h018 && pwdata[7:0] == 8'h0f
      |-> ##[1:2] restoreDefaults;
  endproperty
  a_rot: assert property (p_rot) else $error("no restore");
  property p_led;
    wrC && pwdata[4] |-> ##[1:12] rdyLedYellow;
  endproperty
  a_led: assert property (p_led) else $error("no ready flash");
  property p_net;
    wrC && pwdata[3] |-> ##[1:12] netLedGreen;
  endproperty
  a_net: assert property (p_net) else $error("no net green");
  property p_cyc;
    rdS && paddr == 12'h014 && up_r > 8'h2d && !restoreDefaults
      |=> prdata[9:8] == 2'h3;
  endproperty
  a_cyc: assert property (p_cyc) else $error("not ready");
  property p_err;
    psel && penable && paddr == 12'h01c |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no bus error");
endmodule // cioimg_chk
`default_nettype wire

// ===== test_configurable_io_process_image.sv
// Self-checking bench for the process image block
`timescale 1ns/1ns
`default_nettype none
module test_configurable_io_process_image;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, netLedGreen, rdyLedYellow, restoreDefaults;
  logic [15:0] chanIn, chanOut, chanOutEn, o, p, e, fld = 16'h0000;
  logic [3:0]  flt = 4'h0, f;
  logic        rflt = 1'b0;
  logic [63:0] q[$];
  int          failures = 0, checks_done = 0, cyc = 0;
  always #20 clk = ~clk;
  cioimg_top #(.CONN_CYC(20), .CYC_CYC(40), .RING_CYC(10), .BLINK_CYC(4))
    dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chanIn(chanIn),
    .chanOut(chanOut), .chanOutEn(chanOutEn), .faultShort(flt[0]),
    .faultOverload(flt[1]), .faultSupplyOvl(flt[2]),
    .faultUnderVolt(flt[3]), .ringFault(rflt),
    .netLedGreen(netLedGreen), .rdyLedYellow(rdyLedYellow),
    .restoreDefaults(restoreDefaults));
  cioimg_field fld_u (.chanOut(chanOut), .chanOutEn(chanOutEn),
    .fieldLvl(fld), .chanIn(chanIn));
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Settling gap lets the one-cycle image lag land before the read
  task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
    repeat (3) @(posedge clk);
    q.push_back({m, x});
    xfer(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [63:0] n);
    checks_done++;
    if ((g & n[63:32]) !== n[31:0]) begin
      failures++;
      $display("[ERR] %0t read %h want %h", $time, g, n[31:0]);
    end
  endtask
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) cmp(prdata, q.pop_front());
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h8d17));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (50) @(posedge clk);
    rd(12'h014, 32'h0000_0300, 32'h0000_0300);
    for (int i = 0; i < 5; i++) begin
      f = 4'h1 << i;
      flt <= f;
      rd(12'h00c, 32'hffff_ffff, {26'h0, f[3:2], 2'h0, f[1:0]});
    end
    $display("status test done");
    fld <= 16'($urandom);
    o = 16'($urandom);
    // The scanner opens one exclusive-owner session
    xfer(12'h000, 1'b1, 32'h0000_000f);
    xfer(12'h004, 1'b1, 32'h0000_00ff);
    xfer(12'h004, 1'b1, {24'h00_0000, o[7:0]});
    rd(12'h010, 32'h0000_ffff, {16'h0000, fld[15:8], o[7:0]});
    xfer(12'h004, 1'b1, 32'h0000_ffff);
    xfer(12'h004, 1'b1, {16'h0000, o});
    rd(12'h010, 32'h0000_ffff, {16'h0000, o});
    $display("image test done");
    for (int c = 0; c < 5; c++) begin
      p = 16'($urandom);
      o = 16'($urandom);
      xfer(12'h000, 1'b1, 32'h0000_000f);
      xfer(12'h004, 1'b1, {16'h0000, o});
      xfer(12'h008, 1'b1, {8'h00, p, 8'(c)});
      xfer(12'h000, 1'b1, 32'h0000_000b);
      e = c == 0 ? 16'h0000 : c == 1 ? 16'hffff : c == 2 ? o : p;
      rd(12'h010, 32'h0000_ffff, {16'h0000, e});
    end
    $display("substitute test done");
    rflt <= 1'b1;
    @(posedge clk);
    rflt <= 1'b0;
    rd(12'h014, 32'h0000_0800, 32'h0000_0800);
    repeat (20) @(posedge clk);
    rd(12'h014, 32'h0000_0800, 32'h0000_0000);
    $display("ring test done");
    xfer(12'h000, 1'b1, 32'h0000_001f);
    repeat (12) @(posedge clk);
    rd(12'h01c, 32'hffff_ffff, 32'h0000_0000);
    xfer(12'h018, 1'b1, 32'h0000_000f);
    rd(12'h014, 32'h0000_0400, 32'h0000_0400);
    rd(12'h010, 32'h0000_ffff, {16'h0000, fld});
    $display("restore test done");
    finish_test();
  end
endmodule // test_configurable_io_process_image
bind cioimg_top cioimg_chk chk_u (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .chanIn(chanIn), .chanOut(chanOut),
  .chanOutEn(chanOutEn), .faultShort(faultShort),
  .faultOverload(faultOverload), .faultSupplyOvl(faultSupplyOvl),
  .faultUnderVolt(faultUnderVolt), .netLedGreen(netLedGreen),
  .rdyLedYellow(rdyLedYellow), .restoreDefaults(restoreDefaults),
  .pslverr(pslverr));
`default_nettype wire
